// File: src/watchdog_pkg.sv
// Purpose: constants for the watchdog timeout and reset block
// Assumes: one system clock at 100 MHz, synchronous active-high reset
// Notes: timeout lengths are powers of two of system clock cycles

// ****************************************
// constants
// ****************************************
package watchdog_pkg;
  localparam int unsigned CNT_W = 24;
  localparam logic [1:0] SEL_2P15 = 2'h0;
  localparam logic [1:0] SEL_2P18 = 2'h1;
  localparam logic [1:0] SEL_2P21 = 2'h2;
  localparam logic [1:0] SEL_2P24 = 2'h3;
  localparam int unsigned EXP_2P15 = 15;
  localparam int unsigned EXP_2P18 = 18;
  localparam int unsigned EXP_2P21 = 21;
  localparam int unsigned EXP_2P24 = 24;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam int unsigned RESET_DELAY_CYCLES = 512;
  localparam logic [9:0] RESET_DELAY_LAST = 10'(RESET_DELAY_CYCLES - 1);
  localparam logic [1:0] SEL_RESET = 2'h0;

  typedef enum logic [1:0] {
    WD_COUNT,
    WD_GRACE,
    WD_RESET
  } wd_state_type;
endpackage

// File: src/watchdog_timeout_reset.sv
// Purpose: watchdog that warns by interrupt and then resets the device
// Assumes: software restart is a one-cycle pulse synchronous to clk_i
// Notes: reset request is a one-cycle pulse; the system reset clears this block
`timescale 1ns/100ps

module watchdog_timeout_reset
  import watchdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] timeout_select_i,
  input wire logic irq_enable_i,
  input wire logic restart_i,
  output logic irq_o,
  output logic sys_reset_o,
  output logic timeout_flag_o
);

  // ****************************************
  // helpers
  // ****************************************
  // last count value for the selected interval, one below the power of two
  function automatic logic [CNT_W-1:0] last_count(input logic [1:0] sel);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1};
    case (sel)
      SEL_2P15: begin
        last_count = CNT_W'((one << EXP_2P15) - 1'b1);
      end
      SEL_2P18: begin
        last_count = CNT_W'((one << EXP_2P18) - 1'b1);
      end
      SEL_2P21: begin
        last_count = CNT_W'((one << EXP_2P21) - 1'b1);
      end
      SEL_2P24: begin
        last_count = CNT_W'((one << EXP_2P24) - 1'b1);
      end
      default: begin
        last_count = CNT_W'((one << EXP_2P24) - 1'b1);
      end
    endcase
  endfunction

  // the counter has reached the end of the selected interval
  function automatic logic interval_done(input logic [CNT_W-1:0] cnt, input logic [1:0] sel);
    interval_done = (cnt == last_count(sel));
  endfunction

  // one counter step; an interval shortened below the count runs round through zero
  function automatic logic [CNT_W-1:0] step_count(input logic [CNT_W-1:0] cnt);
    step_count = cnt + 1'b1;
  endfunction

  // one step of the grace counter
  function automatic logic [9:0] step_grace(input logic [9:0] grace);
    step_grace = grace + 1'b1;
  endfunction

  // ****************************************
  // state
  // ****************************************
  wd_state_type state_ff;
  wd_state_type nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [9:0] grace_ff;
  logic [9:0] nxt_grace;
  logic irq_ff;
  logic nxt_irq;
  logic rst_req_ff;
  logic nxt_rst_req;
  logic flag_ff;
  logic nxt_flag;
  logic kick;
  logic expire;
  logic grace_end;

  // ****************************************
  // decode
  // ****************************************
  // a restart after the reset request is refused until the system reset arrives
  always_comb begin
    kick = restart_i && (state_ff != WD_RESET);
    expire = (state_ff == WD_COUNT) && interval_done(cnt_ff, timeout_select_i);
    grace_end = (state_ff == WD_GRACE) && (grace_ff == RESET_DELAY_LAST);
  end

  // ****************************************
  // sequence
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WD_COUNT: begin
        if (expire) begin
          nxt_state = WD_GRACE;
        end
      end
      WD_GRACE: begin
        if (grace_end) begin
          nxt_state = WD_RESET;
        end
      end
      WD_RESET: begin
        // holds until the system reset clears the block
        nxt_state = WD_RESET;
      end
      default: begin
        nxt_state = WD_COUNT;
      end
    endcase
    // restart wins over a same-cycle expiry or grace end
    if (kick) begin
      nxt_state = WD_COUNT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= WD_COUNT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // interval counter
  // ****************************************
  // frozen in the hold state so the last count stays visible until reset
  always_comb begin
    nxt_cnt = step_count(cnt_ff);
    if (state_ff == WD_RESET) begin
      nxt_cnt = cnt_ff;
    end
    if (expire) begin
      nxt_cnt = CNT_RESET;
    end
    if (kick) begin
      nxt_cnt = CNT_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************
  // grace counter
  // ****************************************
  // counts the cycles between the warning and the reset request
  always_comb begin
    nxt_grace = grace_ff;
    if (state_ff == WD_GRACE) begin
      nxt_grace = step_grace(grace_ff);
    end
    if (expire) begin
      nxt_grace = 10'h000;
    end
    if (kick) begin
      nxt_grace = 10'h000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grace_ff <= 10'h000;
    end else begin
      grace_ff <= nxt_grace;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // irq_enable_i only matters in the expiry cycle; enabling it later raises nothing
  always_comb begin
    nxt_irq = expire && irq_enable_i;
    nxt_rst_req = grace_end;
    nxt_flag = flag_ff;
    if (expire) begin
      nxt_flag = 1'b1;
    end
    if (kick) begin
      nxt_irq = 1'b0;
      nxt_rst_req = 1'b0;
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      rst_req_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
      rst_req_ff <= nxt_rst_req;
      flag_ff <= nxt_flag;
    end
  end

  // ****************************************
  // ports
  // ****************************************
  assign irq_o = irq_ff;
  assign sys_reset_o = rst_req_ff;
  assign timeout_flag_o = flag_ff;

endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the watchdog
// Assumes: shortest interval only; longer ones exceed the run length
// Notes: three 2^15 timeouts, one restart in grace
`timescale 1ns/100ps
module testbench;
  import watchdog_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, irq_enable_i = 1'h1, restart_i = 1'h0;
  logic [1:0] timeout_select_i = SEL_2P15;
  logic irq_o, sys_reset_o, timeout_flag_o;
  int n_fail = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  watchdog_timeout_reset DUT (.clk_i(clk_i), .rst_i(rst_i), .timeout_select_i(timeout_select_i),
    .irq_enable_i(irq_enable_i), .restart_i(restart_i), .irq_o(irq_o),
    .sys_reset_o(sys_reset_o), .timeout_flag_o(timeout_flag_o));
  task chk(input bit c, input string m);
    n_compared++;
    if (!c) begin
      n_fail++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task do_reset;
    @(posedge clk_i) rst_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask
  task t_expire;
    repeat (32767) @(posedge clk_i);
    #1 chk(irq_o === 1'h0, "early irq");
    @(posedge clk_i) #1 chk(irq_o === 1'h1 && timeout_flag_o === 1'h1, "no irq");
    repeat (511) @(posedge clk_i);
    #1 chk(sys_reset_o === 1'h0, "early reset");
    @(posedge clk_i) #1 chk(sys_reset_o === 1'h1, "no reset");
    $display("expire test done");
  endtask
  task t_restart;
    irq_enable_i <= 1'h0;
    repeat (32768) @(posedge clk_i);
    #1 chk(irq_o === 1'h0 && timeout_flag_o === 1'h1, "masked irq");
    repeat (100) @(posedge clk_i);
    restart_i <= 1'h1;
    @(posedge clk_i) restart_i <= 1'h0;
    #1 chk(timeout_flag_o === 1'h0, "flag kept");
    repeat (32767) @(posedge clk_i);
    #1 chk(timeout_flag_o === 1'h0 && sys_reset_o === 1'h0, "early timeout");
    @(posedge clk_i) #1 chk(timeout_flag_o === 1'h1, "no timeout");
    $display("restart test done");
  endtask
  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    do_reset;
    t_expire;
    do_reset;
    t_restart;
    tally_and_finish;
  end
  // about 99k cycles expected, so a hang is cut at 110k
  initial begin
    #1100000;
    n_fail++;
    tally_and_finish;
  end
endmodule

// File: tb/watchdog_chk_assertions.sv
// Purpose: port checks for the watchdog
// Assumes: one clock, synchronous reset
// Notes: helper counters mirror elapsed time
`timescale 1ns/100ps
module watchdog_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] timeout_select_i,
  input wire logic irq_enable_i,
  input wire logic restart_i,
  input wire logic irq_o,
  input wire logic sys_reset_o,
  input wire logic timeout_flag_o
);
  logic [24:0] ccnt_ff;
  logic [9:0] gcnt_ff;
  // grace count saturates so a long hold state cannot wrap back onto the reset cycle
  always_ff @(posedge clk_i) begin
    ccnt_ff <= (rst_i || restart_i) ? 25'h0 : ccnt_ff + 25'h1;
    if (!timeout_flag_o) begin
      gcnt_ff <= 10'h0;
    end else if (gcnt_ff != 10'h3ff) begin
      gcnt_ff <= gcnt_ff + 10'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_hold; timeout_flag_o && !restart_i |=> timeout_flag_o; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_range; $rose(timeout_flag_o) |-> ccnt_ff >= 25'h8000 && ccnt_ff <= 25'h1000000;
  endproperty
  a_range: assert property (p_range) else $error("interval out of range");
  property p_sel; $rose(timeout_flag_o) |->
    ccnt_ff == 25'h8000 << (3 * $past(timeout_select_i)); endproperty
  a_sel: assert property (p_sel) else $error("interval wrong");
  property p_irq; $rose(timeout_flag_o) || irq_o |->
    irq_o == ($rose(timeout_flag_o) && $past(irq_enable_i)); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_rst; timeout_flag_o && gcnt_ff == 10'h1ff && !restart_i |=> sys_reset_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset late");
  property p_clr; restart_i && gcnt_ff < 10'h200 |=> !timeout_flag_o && !sys_reset_o;
  endproperty
  a_clr: assert property (p_clr) else $error("restart ignored");
endmodule
bind watchdog_timeout_reset watchdog_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .timeout_select_i(timeout_select_i), .irq_enable_i(irq_enable_i), .restart_i(restart_i),
  .irq_o(irq_o), .sys_reset_o(sys_reset_o), .timeout_flag_o(timeout_flag_o));
